// ===== rtl/i2cbb_pkg.sv
// constants and types shared by both ends of the two-wire slave port
// assumes a 25 MHz ref_clk_i on both ends and an open-drain bus
package i2cbb_pkg;
	localparam int CLK_KHZ   = 25000;
	localparam int CLK_NS    = 40;
	localparam int SPIKE_NS  = 50;
	localparam int FILT_CYC  = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCL_KHZ   = 100;
	localparam int QTR_CYC   = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
	localparam int BYTE_BITS = 8;
	localparam int PTR_W     = 8;
	localparam int DAT_W     = 8;
	localparam int FIFO_DEP  = 2;
	localparam logic [6:0] ADDR_VBATT = 7'h7f;
	localparam logic [6:0] ADDR_FLOAT = 7'h7c;
	localparam logic [6:0] ADDR_GND   = 7'h7d;
	localparam logic [1:0] SEL_GND    = 2'h0;
	localparam logic [1:0] SEL_VBATT  = 2'h1;
	localparam logic [1:0] SEL_FLOAT  = 2'h2;
	typedef enum logic [1:0] {
		CMD_START,
		CMD_STOP,
		CMD_WRITE,
		CMD_READ
	} i2cbb_cmd_t;
endpackage

// ===== rtl/i2cbb_if.sv
// open-drain two-wire bus joining the host end and the device end
// assumes external pull-ups: a released line reads high
`timescale 1ns/100ps
interface i2cbb_if;
	logic scl_o;
	logic scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// wired-and of all drivers
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport host (
		input  scl,
		input  sda,
		output scl_o,
		output scl_oe,
		output m_sda_o,
		output m_sda_oe
	);
	modport device (
		input  scl,
		input  sda,
		output s_sda_o,
		output s_sda_oe
	);
endinterface

// ===== rtl/i2cbb_slave.sv
// device end: filtered two-wire slave with register pointer and write buffer
// assumes the master clocks the bus and keeps to the bus rules
`timescale 1ns/100ps
module i2cbb_slave #(
	parameter int FIFO_DEPTH = i2cbb_pkg::FIFO_DEP,
	parameter int FIFO_W     = i2cbb_pkg::PTR_W + i2cbb_pkg::DAT_W
) (
	// clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_i,
	// bus
	i2cbb_if.device                     bus,
	// address strap
	input  wire logic [1:0]             addr_sel_i,
	// write stream
	output logic                        wr_valid_o,
	input  wire logic                   wr_ready_i,
	output logic [i2cbb_pkg::PTR_W-1:0] wr_addr_o,
	output logic [i2cbb_pkg::DAT_W-1:0] wr_data_o,
	// read port
	output logic [i2cbb_pkg::PTR_W-1:0] rd_addr_o,
	input  wire logic [i2cbb_pkg::DAT_W-1:0] rd_data_i
);
	localparam int FW = $clog2(i2cbb_pkg::FILT_CYC + 1);
	localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [FW-1:0] FILT_MAX = FW'(i2cbb_pkg::FILT_CYC);
	localparam logic [AW-1:0] LAST_IX  = AW'(FIFO_DEPTH - 1);
	localparam logic [AW-1:0] ONE_IX   = AW'(1);
	localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);
	localparam logic [CW-1:0] ONE_CNT  = CW'(1);
	localparam logic [3:0]    BITS     = 4'(i2cbb_pkg::BYTE_BITS);
	localparam logic [3:0]    TX_LAST  = 4'(i2cbb_pkg::BYTE_BITS - 1);

	typedef enum logic [3:0] {
		S_IDLE,
		S_ADDR,
		S_AACK,
		S_REG,
		S_RACK,
		S_WDAT,
		S_WACK,
		S_TX,
		S_TACK,
		S_IGN
	} i2cbb_st_t;

	////////////////////////////////////////////////////////////////////////
	// synchronisers and spike filters (bit 0 clock, bit 1 data)

	logic [1:0]    s1_r;
	logic [1:0]    s2_r;
	logic [1:0]    sel1_r;
	logic [1:0]    sel2_r;
	logic          flt_r [2];
	logic [FW-1:0] fcnt_r [2];
	logic          prv_r [2];

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_r   <= 2'h3;
			s2_r   <= 2'h3;
			sel1_r <= i2cbb_pkg::SEL_GND;
			sel2_r <= i2cbb_pkg::SEL_GND;
		end else begin
			s1_r   <= {bus.sda, bus.scl};
			s2_r   <= s1_r;
			sel1_r <= addr_sel_i;
			sel2_r <= sel1_r;
		end
	end

	generate
		for (genvar g = 0; g < 2; g++) begin : g_flt
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					flt_r[g]  <= 1'b1;
					fcnt_r[g] <= '0;
					prv_r[g]  <= 1'b1;
				end else begin
					prv_r[g] <= flt_r[g];
					if (s2_r[g] == flt_r[g]) begin
						fcnt_r[g] <= '0;
					end else if (fcnt_r[g] == FILT_MAX) begin
						flt_r[g]  <= s2_r[g];
						fcnt_r[g] <= '0;
					end else begin
						fcnt_r[g] <= fcnt_r[g] + 1'b1;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// bus events

	logic       sda_f;
	logic       scl_rise;
	logic       scl_fall;
	logic       scl_hi;
	logic       sda_fall_hi;
	logic       sda_rise_hi;
	logic       rx_st;
	logic       start_ok;
	logic       start_ev;
	logic       stop_ev;
	logic       abort_ev;
	logic       byte_done;
	logic       addr_hit;
	logic [6:0] sel_addr;
	logic [6:0] own_r;

	i2cbb_st_t                   state_r;
	i2cbb_st_t                   state_nxt;
	logic [7:0]                  sh_r;
	logic [7:0]                  sh_nxt;
	logic [3:0]                  cnt_r;
	logic [3:0]                  cnt_nxt;
	logic                        oe_r;
	logic                        oe_nxt;
	logic                        rw_r;
	logic                        rw_nxt;
	logic                        mack_r;
	logic                        mack_nxt;
	logic [i2cbb_pkg::PTR_W-1:0] ptr_r;
	logic [i2cbb_pkg::PTR_W-1:0] ptr_nxt;
	logic                        push;
	logic                        fifo_rdy;

	assign sda_f       = flt_r[1];
	assign scl_rise    = flt_r[0] & ~prv_r[0];
	assign scl_fall    = ~flt_r[0] & prv_r[0];
	assign scl_hi      = flt_r[0] & prv_r[0];
	assign sda_fall_hi = scl_hi & prv_r[1] & ~flt_r[1];
	assign sda_rise_hi = scl_hi & ~prv_r[1] & flt_r[1];
	assign rx_st       = (state_r == S_ADDR) | (state_r == S_REG) |
	                     (state_r == S_WDAT);
	assign start_ok    = (state_r == S_IDLE) | (state_r == S_IGN) |
	                     (rx_st & (cnt_r <= 4'h1));
	assign start_ev    = sda_fall_hi & start_ok;
	assign stop_ev     = sda_rise_hi;
	assign abort_ev    = sda_fall_hi & ~start_ok;
	assign byte_done   = (cnt_r == BITS);
	assign addr_hit    = (sh_r[7:1] == own_r);
	assign sel_addr    = (sel2_r == i2cbb_pkg::SEL_VBATT) ?
	                     i2cbb_pkg::ADDR_VBATT :
	                     (sel2_r == i2cbb_pkg::SEL_GND) ?
	                     i2cbb_pkg::ADDR_GND : i2cbb_pkg::ADDR_FLOAT;

	// strap follows the pin only while no transaction is open
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			own_r <= i2cbb_pkg::ADDR_GND;
		end else if (state_r == S_IDLE) begin
			own_r <= sel_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transaction state machine

	always_comb begin
		state_nxt = state_r;
		sh_nxt    = sh_r;
		cnt_nxt   = cnt_r;
		oe_nxt    = oe_r;
		rw_nxt    = rw_r;
		mack_nxt  = mack_r;
		ptr_nxt   = ptr_r;
		push      = 1'b0;
		if (start_ev) begin
			state_nxt = S_ADDR;
			cnt_nxt   = 4'h0;
			oe_nxt    = 1'b0;
		end else if (stop_ev | abort_ev) begin
			state_nxt = S_IDLE;
			oe_nxt    = 1'b0;
		end else begin
			unique case (state_r)
				S_IDLE, S_IGN: begin
				end
				S_ADDR, S_REG, S_WDAT: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_f};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && byte_done) begin
						cnt_nxt = 4'h0;
						if (state_r == S_ADDR) begin
							rw_nxt    = sh_r[0];
							oe_nxt    = addr_hit;
							state_nxt = addr_hit ? S_AACK : S_IGN;
						end else if (state_r == S_REG) begin
							ptr_nxt   = sh_r;
							oe_nxt    = 1'b1;
							state_nxt = S_RACK;
						end else begin
							push      = 1'b1;
							mack_nxt  = fifo_rdy;
							oe_nxt    = fifo_rdy;
							state_nxt = S_WACK;
						end
					end
				end
				S_AACK, S_RACK, S_WACK: begin
					if (scl_fall) begin
						oe_nxt = 1'b0;
						if (state_r == S_AACK && rw_r) begin
							state_nxt = S_TX;
							sh_nxt    = rd_data_i;
							oe_nxt    = ~rd_data_i[7];
						end else if (state_r == S_AACK) begin
							state_nxt = S_REG;
						end else begin
							state_nxt = S_WDAT;
							if (state_r == S_WACK && mack_r) begin
								ptr_nxt = ptr_r + 8'h01;
							end
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (cnt_r == TX_LAST) begin
							oe_nxt    = 1'b0;
							state_nxt = S_TACK;
						end else begin
							sh_nxt  = {sh_r[6:0], 1'b0};
							oe_nxt  = ~sh_r[6];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				S_TACK: begin
					if (scl_rise) begin
						mack_nxt = ~sda_f;
						if (!sda_f) begin
							ptr_nxt = ptr_r + 8'h01;
						end
					end else if (scl_fall) begin
						cnt_nxt = 4'h0;
						if (mack_r) begin
							state_nxt = S_TX;
							sh_nxt    = rd_data_i;
							oe_nxt    = ~rd_data_i[7];
						end else begin
							state_nxt = S_IGN;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= S_IDLE;
			sh_r    <= 8'h00;
			cnt_r   <= 4'h0;
			oe_r    <= 1'b0;
			rw_r    <= 1'b0;
			mack_r  <= 1'b0;
			ptr_r   <= 8'h00;
		end else begin
			state_r <= state_nxt;
			sh_r    <= sh_nxt;
			cnt_r   <= cnt_nxt;
			oe_r    <= oe_nxt;
			rw_r    <= rw_nxt;
			mack_r  <= mack_nxt;
			ptr_r   <= ptr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write buffer; a full buffer refuses the byte with a nack

	logic [FIFO_W-1:0] mem_r [FIFO_DEPTH];
	logic [AW-1:0]     wp_r;
	logic [AW-1:0]     rp_r;
	logic [CW-1:0]     fcount_r;
	logic              do_push;
	logic              do_pop;

	assign fifo_rdy = (fcount_r != FULL_CNT);
	assign do_push  = push & fifo_rdy;
	assign do_pop   = wr_valid_o & wr_ready_i;

	always_ff @(posedge ref_clk_i) begin
		if (do_push) begin
			mem_r[wp_r] <= FIFO_W'({ptr_r, sh_r});
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wp_r     <= '0;
			rp_r     <= '0;
			fcount_r <= '0;
		end else begin
			if (do_push) begin
				wp_r <= (wp_r == LAST_IX) ? '0 : wp_r + ONE_IX;
			end
			if (do_pop) begin
				rp_r <= (rp_r == LAST_IX) ? '0 : rp_r + ONE_IX;
			end
			if (do_push && !do_pop) begin
				fcount_r <= fcount_r + ONE_CNT;
			end else if (do_pop && !do_push) begin
				fcount_r <= fcount_r - ONE_CNT;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign wr_valid_o   = (fcount_r != '0);
	assign {wr_addr_o, wr_data_o} = (fcount_r != '0) ?
	                     (i2cbb_pkg::PTR_W + i2cbb_pkg::DAT_W)'(mem_r[rp_r]) :
	                     '0;
	assign rd_addr_o    = ptr_r;
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = oe_r;
endmodule

// ===== rtl/i2cbb_master.sv
// host end: command-driven two-wire master making the clock by a divider
// assumes one device end on the bus and a user that waits for done_o
`timescale 1ns/100ps
module i2cbb_master #(
	parameter int QTR = i2cbb_pkg::QTR_CYC
) (
	// clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_i,
	// bus
	i2cbb_if.host                       bus,
	// command
	input  wire logic                   cmd_valid_i,
	output logic                        cmd_ready_o,
	input  wire i2cbb_pkg::i2cbb_cmd_t  cmd_i,
	input  wire logic [7:0]             cmd_data_i,
	input  wire logic                   cmd_nack_i,
	// result
	output logic                        done_o,
	output logic [7:0]                  rd_data_o,
	output logic                        ack_o
);
	localparam int QW = $clog2(QTR + 1);
	localparam logic [QW-1:0] Q_LAST = QW'(QTR - 1);
	localparam logic [3:0]    B_LAST = 4'(i2cbb_pkg::BYTE_BITS);

	typedef enum logic {
		M_IDLE,
		M_RUN
	} i2cbb_mst_t;

	////////////////////////////////////////////////////////////////////////
	// data line synchroniser

	logic s1_r;
	logic s2_r;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
		end else begin
			s1_r <= bus.sda;
			s2_r <= s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// quarter-bit sequencer

	i2cbb_mst_t            st_r;
	i2cbb_mst_t            st_nxt;
	i2cbb_pkg::i2cbb_cmd_t op_r;
	i2cbb_pkg::i2cbb_cmd_t op_nxt;
	logic [QW-1:0]         q_r;
	logic [QW-1:0]         q_nxt;
	logic [1:0]            ph_r;
	logic [1:0]            ph_nxt;
	logic [3:0]            bit_r;
	logic [3:0]            bit_nxt;
	logic [8:0]            tx_r;
	logic [8:0]            tx_nxt;
	logic [8:0]            rx_r;
	logic [8:0]            rx_nxt;
	logic                  scl_r;
	logic                  scl_nxt;
	logic                  sda_r;
	logic                  sda_nxt;
	logic                  done_nxt;
	logic                  q_end;
	logic                  is_byte;
	logic                  take;

	assign q_end       = (q_r == Q_LAST);
	assign is_byte     = (op_r == i2cbb_pkg::CMD_WRITE) |
	                     (op_r == i2cbb_pkg::CMD_READ);
	assign cmd_ready_o = (st_r == M_IDLE);
	assign take        = cmd_valid_i & cmd_ready_o;

	always_comb begin
		st_nxt   = st_r;
		op_nxt   = op_r;
		q_nxt    = q_r;
		ph_nxt   = ph_r;
		bit_nxt  = bit_r;
		tx_nxt   = tx_r;
		rx_nxt   = rx_r;
		scl_nxt  = scl_r;
		sda_nxt  = sda_r;
		done_nxt = 1'b0;
		if (take) begin
			st_nxt  = M_RUN;
			op_nxt  = cmd_i;
			q_nxt   = '0;
			ph_nxt  = 2'h0;
			bit_nxt = 4'h0;
			tx_nxt  = (cmd_i == i2cbb_pkg::CMD_READ) ?
			          {8'hff, cmd_nack_i} : {cmd_data_i, 1'b1};
		end else if (st_r == M_RUN) begin
			q_nxt = q_end ? '0 : q_r + 1'b1;
			unique case (op_r)
				i2cbb_pkg::CMD_START: begin
					scl_nxt = (ph_r == 2'h1) | (ph_r == 2'h2);
					sda_nxt = (ph_r == 2'h0) | (ph_r == 2'h1);
				end
				i2cbb_pkg::CMD_STOP: begin
					scl_nxt = (ph_r != 2'h0);
					sda_nxt = ph_r[1];
				end
				default: begin
					scl_nxt = (ph_r == 2'h2);
					sda_nxt = (ph_r == 2'h0) ? sda_r : tx_r[8];
				end
			endcase
			if (q_end) begin
				ph_nxt = ph_r + 2'h1;
				if (is_byte && ph_r == 2'h2) begin
					rx_nxt = {rx_r[7:0], s2_r};
				end
				if (ph_r == 2'h3) begin
					if (is_byte && bit_r != B_LAST) begin
						bit_nxt = bit_r + 4'h1;
						tx_nxt  = {tx_r[7:0], 1'b1};
					end else begin
						st_nxt   = M_IDLE;
						done_nxt = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r   <= M_IDLE;
			op_r   <= i2cbb_pkg::CMD_STOP;
			q_r    <= '0;
			ph_r   <= 2'h0;
			bit_r  <= 4'h0;
			tx_r   <= 9'h1ff;
			rx_r   <= 9'h000;
			scl_r  <= 1'b1;
			sda_r  <= 1'b1;
			done_o <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			op_r   <= op_nxt;
			q_r    <= q_nxt;
			ph_r   <= ph_nxt;
			bit_r  <= bit_nxt;
			tx_r   <= tx_nxt;
			rx_r   <= rx_nxt;
			scl_r  <= scl_nxt;
			sda_r  <= sda_nxt;
			done_o <= done_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign rd_data_o    = rx_r[8:1];
	assign ack_o        = ~rx_r[0];
	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = ~scl_r;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = ~sda_r;
endmodule

// ===== sim/i2cbb_props.sv
// concurrent checks on the wires joining the host end and the device end
// assumes the host end runs with QTR cycles per quarter bit
`timescale 1ns/100ps
module i2cbb_props #(
	parameter int QTR = i2cbb_pkg::QTR_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// host drivers
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	// device drivers
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	// resolved wires
	input wire logic scl,
	input wire logic sda
);
	localparam int CLOSE_MAX = QTR + 2;
	logic       scl_q_r;
	logic       sda_q_r;
	logic       seen_r;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	wire        start_ev = scl & scl_q_r & sda_q_r & ~sda;
	wire        stop_ev  = scl & scl_q_r & ~sda_q_r & sda;
	wire        rise_ev  = scl & ~scl_q_r;
	wire [3:0]  bit_inc  = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;

	// scl rises since the last start or stop, modulo nine
	assign bit_nxt = (start_ev | stop_ev) ? 4'h0 :
	                 (rise_ev ? bit_inc : bit_r);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			seen_r  <= 1'b0;
			bit_r   <= 4'h0;
		end else begin
			scl_q_r <= scl;
			sda_q_r <= sda;
			seen_r  <= seen_r | start_ev;
			bit_r   <= bit_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_released8;
		!s_sda_oe [*8];
	endsequence
	sequence s_close;
		##[1:CLOSE_MAX] !scl;
	endsequence

	a_dev_sda_low: assert property ($changed(s_sda_oe) |-> !scl)
		else $error("device data moved while clock high");
	a_dev_filter_lag: assert property ($changed(s_sda_oe) |-> !$past(scl, 4))
		else $error("device data moved too soon after clock fall");
	a_start_close: assert property (start_ev |-> s_close)
		else $error("clock not lowered after start");
	a_idle_release: assert property ($fell(reset_i) |-> scl && sda && !s_sda_oe)
		else $error("lines not released after reset");
	a_clock_high_min: assert property ($rose(scl) |=> scl [*7])
		else $error("clock high phase too short");
	a_stop_release: assert property (stop_ev |-> s_released8)
		else $error("device drives data after stop");
	a_start_release: assert property (start_ev |-> s_released8)
		else $error("device drives data after start");
	a_byte_frame: assert property ((start_ev || stop_ev) && seen_r |-> bit_r == 4'h1)
		else $error("frame not a whole number of bytes");
endmodule

// ===== sim/i2cbb_test.sv
// self-checking bench: host end and device end on one bus, plus a
// bench-driven bus carrying spikes and an aborted byte to a second device
// assumes the hand-over timing of both ends with a quarter bit of 12
`timescale 1ns/100ps
module i2cbb_test;
	localparam int QTR = 12;
	localparam logic [1:0] SEL_TAB [5] = '{i2cbb_pkg::SEL_GND,
		i2cbb_pkg::SEL_VBATT, i2cbb_pkg::SEL_FLOAT, 2'h3,
		i2cbb_pkg::SEL_GND};
	localparam logic [6:0] ADR_TAB [5] = '{i2cbb_pkg::ADDR_GND,
		i2cbb_pkg::ADDR_VBATT, i2cbb_pkg::ADDR_FLOAT,
		i2cbb_pkg::ADDR_FLOAT, 7'h7e};
	logic                  ref_clk_i = 1'b0;
	logic                  reset_i   = 1'b1;
	logic                  cmd_valid = 1'b0;
	i2cbb_pkg::i2cbb_cmd_t cmd_kind  = i2cbb_pkg::CMD_START;
	logic [7:0]            cmd_data  = 8'h00;
	logic                  cmd_nack  = 1'b0;
	logic [1:0]            sel       = 2'h0;
	logic                  wr_ready  = 1'b0;
	logic                  cmd_ready, done, ack, wr_valid, wr_valid_b, a;
	logic [7:0]            rd_data, rd_addr, wr_addr, wr_data;
	int                    fail_count = 0;
	int                    checks     = 0;
	int                    cyc        = 0;
	i2cbb_if bus ();
	i2cbb_if bus_b ();

	i2cbb_master #(.QTR(QTR)) i_i2cbb_master (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .bus(bus.host), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_i(cmd_kind), .cmd_data_i(cmd_data),
		.cmd_nack_i(cmd_nack), .done_o(done), .rd_data_o(rd_data),
		.ack_o(ack));
	i2cbb_slave i_i2cbb_slave (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.bus(bus.device), .addr_sel_i(sel), .wr_valid_o(wr_valid),
		.wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
		.rd_addr_o(rd_addr), .rd_data_i(rd_addr ^ 8'h5a));
	i2cbb_slave i_i2cbb_slave_b (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.bus(bus_b.device), .addr_sel_i(i2cbb_pkg::SEL_GND),
		.wr_valid_o(wr_valid_b), .wr_ready_i(1'b0), .wr_addr_o(),
		.wr_data_o(), .rd_addr_o(), .rd_data_i(8'h00));
	i2cbb_props #(.QTR(QTR)) i_i2cbb_props (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
		.m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
		.s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl),
		.sda(bus.sda));

	always #20 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one host command, waiting for its completion pulse
	task automatic mcmd(input i2cbb_pkg::i2cbb_cmd_t k, input logic [7:0] d,
		input logic nk);
		int n;
		n = 0;
		cmd_kind <= k;
		cmd_data <= d;
		cmd_nack <= nk;
		cmd_valid <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (cmd_ready !== 1'b1 && n < 100);
		cmd_valid <= 1'b0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (done !== 1'b1 && n < 2000);
		check("done", {7'h00, done}, 8'h01);
	endtask

	task automatic wr(input logic [7:0] d, input logic exp_ack);
		mcmd(i2cbb_pkg::CMD_WRITE, d, 1'b0);
		check("write ack", {7'h00, ack}, {7'h00, exp_ack});
	endtask

	task automatic rd(input logic nk, input logic [7:0] exp);
		mcmd(i2cbb_pkg::CMD_READ, 8'h00, nk);
		check("read data", rd_data, exp);
		check("read ack", {7'h00, ack}, {7'h00, ~nk});
	endtask

	// bench-driven bus: levels held for n cycles
	task automatic bb(input logic c, input logic d, input int n);
		bus_b.scl_oe <= ~c;
		bus_b.m_sda_oe <= ~d;
		repeat (n) @(posedge ref_clk_i);
	endtask

	// byte with one-cycle spikes; bit cut pulls data low mid-high
	task automatic bbyte(input logic [7:0] v, input int cut, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bb(1'b0, v[i], 6);
			bb(1'b1, v[i], 1);
			bb(1'b0, v[i], 17);
			bb(1'b1, v[i], 10);
			bb(1'b1, 1'b0, 1);
			bb(1'b1, v[i] && i != cut, 13);
		end
		bb(1'b0, 1'b1, 24);
		bb(1'b1, 1'b1, 12);
		k = ~bus_b.sda;
		bb(1'b1, 1'b1, 12);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		bus_b.scl_o = 1'b0;
		bus_b.m_sda_o = 1'b0;
		bus_b.scl_oe = 1'b0;
		bus_b.m_sda_oe = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		// address strap table and a foreign address
		for (int k = 0; k < 5; k++) begin
			sel <= SEL_TAB[k];
			repeat (8) @(posedge ref_clk_i);
			mcmd(i2cbb_pkg::CMD_START, 8'h00, 1'b0);
			wr({ADR_TAB[k], 1'b0}, k != 4);
			wr(8'h33, k != 4);
			mcmd(i2cbb_pkg::CMD_STOP, 8'h00, 1'b0);
		end
		$display("test address done");
		// burst write with the receiver stalled until the buffer refuses
		sel <= i2cbb_pkg::SEL_GND;
		mcmd(i2cbb_pkg::CMD_START, 8'h00, 1'b0);
		wr({i2cbb_pkg::ADDR_GND, 1'b0}, 1'b1);
		wr(8'hfe, 1'b1);
		wr(8'h11, 1'b1);
		wr(8'h22, 1'b1);
		wr(8'h33, 1'b0);
		mcmd(i2cbb_pkg::CMD_STOP, 8'h00, 1'b0);
		check("pointer", rd_addr, 8'h00);
		for (int k = 0; k < 2; k++) begin
			check("word valid", {7'h00, wr_valid}, 8'h01);
			check("word addr", wr_addr, 8'hfe + 8'(k));
			check("word data", wr_data, 8'h11 * 8'(k + 1));
			wr_ready <= 1'b1;
			@(posedge ref_clk_i);
			wr_ready <= 1'b0;
			@(posedge ref_clk_i);
		end
		check("word valid", {7'h00, wr_valid}, 8'h00);
		$display("test write done");
		// pointer set, repeated start, read with ack then nack
		wr_ready <= 1'b1;
		mcmd(i2cbb_pkg::CMD_START, 8'h00, 1'b0);
		wr({i2cbb_pkg::ADDR_GND, 1'b0}, 1'b1);
		wr(8'h7f, 1'b1);
		mcmd(i2cbb_pkg::CMD_START, 8'h00, 1'b0);
		wr({i2cbb_pkg::ADDR_GND, 1'b1}, 1'b1);
		rd(1'b0, 8'h7f ^ 8'h5a);
		rd(1'b1, 8'h80 ^ 8'h5a);
		mcmd(i2cbb_pkg::CMD_STOP, 8'h00, 1'b0);
		check("pointer", rd_addr, 8'h80);
		$display("test read done");
		// bench-made bus: spikes filtered, byte aborted mid-way
		bb(1'b1, 1'b0, 24);
		bbyte({i2cbb_pkg::ADDR_GND, 1'b0}, -1, a);
		check("spiked ack", {7'h00, a}, 8'h01);
		bbyte(8'h40, -1, a);
		check("pointer ack", {7'h00, a}, 8'h01);
		bbyte(8'hff, 4, a);
		check("aborted ack", {7'h00, a}, 8'h00);
		check("aborted word", {7'h00, wr_valid_b}, 8'h00);
		bb(1'b0, 1'b0, 24);
		bb(1'b1, 1'b0, 24);
		bb(1'b1, 1'b1, 24);
		$display("test abort done");
		report_and_stop();
	end
endmodule
